// >>> common/padc_pkg.sv
// Shared constants and carrier types for the pipelined converter output port
package padc_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_W      = 12;             // Output word width
    localparam int TOP_BIT_POS = 11;             // Bit flipped by the format select
    localparam int LATENCY     = 5;              // Encode cycles from sample to output
    localparam int STAGES      = 4;              // Pipelined conversion stages

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [11:0] WORD_RST  = 12'h000; // Output word after reset
    localparam logic        FLAG_RST  = 1'b0;    // Range flag after reset
    localparam logic        VALID_RST = 1'b0;    // Strobe level after reset

    // Gain codes for the front end
    localparam logic        GAIN_UNITY = 1'b0;   // Effective gain 1
    localparam logic        GAIN_HIGH  = 1'b1;   // Effective gain 1 2/3

    // One sample moving down the pipeline: word plus its range flag
    typedef struct packed {
        logic              rangeOver;
        logic [WORD_W-1:0] code;
    } padc_sample_t;

endpackage

// >>> rtl/padc_edge_sync.sv
// Two-flop synchroniser with edge detection for the encode pair
`timescale 1ns/1ns
module padc_edge_sync
    import padc_pkg::*;
(
    input  wire logic clk,        // System clock
    input  wire logic rst_n,      // Asynchronous reset, active low
    input  wire logic encTrue,    // True encode input, pin domain
    input  wire logic encComp,    // Complement encode input, pin domain
    output logic      encHigh,    // Synchronised phase level
    output logic      encRise,    // One-cycle pulse on the rising phase edge
    output logic      encFall     // One-cycle pulse on the falling phase edge
);

    // ------------------------------------------------------------
    // Phase decode and synchroniser
    // ------------------------------------------------------------
    logic meta_q;                 // First stage, read only by syncd_q
    logic syncd_q;                // Second stage
    logic prev_q;                 // Delayed copy for edges

    // The pair reads high only when true exceeds complement; a tie counts as low
    // Phase from the pair is combined before syncing so both pins share one path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q  <= 1'b0;
            syncd_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            meta_q  <= encTrue & ~encComp;
            syncd_q <= meta_q;
            prev_q  <= syncd_q;
        end
    end

    assign encHigh = syncd_q;
    assign encRise = syncd_q & ~prev_q;
    assign encFall = ~syncd_q & prev_q;

endmodule

// >>> rtl/padc_output_port.sv
// Digital output port of the pipelined converter: latency, format, range flag, strobe
`timescale 1ns/1ns
//
// Contract
// - Sample taken on rising encode pair edge
// - Pair high when true exceeds complement
// - Result appears five encode cycles later
// - Format low inverts top bit
// - Range flag high for out-of-range input
// - Twelve-bit parallel output word
// - Gain select one or one and two-thirds
module padc_output_port
    import padc_pkg::*;
(
    input  wire logic              clk,              // System clock, 250 MHz
    input  wire logic              rst_n,            // Asynchronous reset, active low
    input  wire logic              encTrue,          // Encode pair, true side (pin)
    input  wire logic              encComp,          // Encode pair, complement side (pin)
    input  wire logic [WORD_W-1:0] quantCode,        // Quantised code from the analog core
    input  wire logic              quantOver,        // Core saw input beyond range
    input  wire logic              topBitInvertSel,  // Low: two's complement, high: offset binary
    input  wire logic              frontGainSel,     // Low: gain 1, high: gain 1 2/3
    output logic [WORD_W-1:0]      sampleWord,       // Parallel result word
    output logic                   rangeOverflowFlag,// Range flag of the same sample
    output logic                   dataValidStrobe,  // Data valid strobe
    output logic                   gainHigh          // Applied front-end gain code
);

    // ------------------------------------------------------------
    // Encode pair synchronisation
    // ------------------------------------------------------------
    logic encHigh;               // Synced phase
    logic encRise;               // Sample instant
    logic encFall;               // Falling edge

    padc_edge_sync uSync (
        .clk     (clk),
        .rst_n   (rst_n),
        .encTrue (encTrue),
        .encComp (encComp),
        .encHigh (encHigh),
        .encRise (encRise),
        .encFall (encFall)
    );

    // ------------------------------------------------------------
    // Static control pins
    // ------------------------------------------------------------
    logic [1:0] invSync_q;       // Format select synchroniser
    logic [1:0] gainSync_q;      // Gain select synchroniser

    // Static pins still pass two flops, they come from off-chip
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            invSync_q  <= 2'h0;
            gainSync_q <= 2'h0;
        end else begin
            invSync_q  <= {invSync_q[0], topBitInvertSel};
            gainSync_q <= {gainSync_q[0], frontGainSel};
        end
    end

    // Gain only scales the analog range; digitally it is reported as a code
    assign gainHigh = (gainSync_q[1] == GAIN_HIGH);

    // ------------------------------------------------------------
    // Core inputs: async to clk, captured through two flops on every clock
    // ------------------------------------------------------------
    padc_sample_t coreSync_q [2];  // Two-flop capture of the core result

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreSync_q[0] <= '0;
            coreSync_q[1] <= '0;
        end else begin
            coreSync_q[0] <= '{rangeOver: quantOver, code: quantCode};
            coreSync_q[1] <= coreSync_q[0];
        end
    end

    // ------------------------------------------------------------
    // Conversion pipeline
    // ------------------------------------------------------------
    // Word and flag ride as one struct so they can never drift apart
    padc_sample_t pipe_q [LATENCY];  // Slot 0 holds the newest sample

    // Advance one slot per encode rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_q[i] <= '{rangeOver: FLAG_RST, code: WORD_RST};
            end
        end else if (encRise) begin
            pipe_q[0] <= coreSync_q[1];
            for (int i = 1; i < LATENCY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    // ------------------------------------------------------------
    // Output formatting
    // ------------------------------------------------------------
    function automatic logic [WORD_W-1:0] fmt_word(input logic [WORD_W-1:0] c, input logic inv);
        logic [WORD_W-1:0] r;
        r = c;
        r[TOP_BIT_POS] = inv ? c[TOP_BIT_POS] : ~c[TOP_BIT_POS];
        return r;
    endfunction

    // Outputs move at the encode rise and take the old tail slot, which entered
    // slot 0 five rises earlier. The strobe is low then and comes back only at the
    // fall, so the receiver sees half an encode period of settled data first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampleWord        <= WORD_RST;
            rangeOverflowFlag <= FLAG_RST;
        end else if (encRise) begin
            sampleWord        <= fmt_word(pipe_q[LATENCY-1].code, invSync_q[1]);
            rangeOverflowFlag <= pipe_q[LATENCY-1].rangeOver;
        end
    end

    // Strobe drops with the rise that moves the word and returns at the fall
    // Moving word and strobe on one clock would leave the receiver no setup time
    logic strobe_q;                   // Strobe level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= VALID_RST;
        end else if (encRise) begin
            strobe_q <= 1'b0;
        end else if (encFall) begin
            strobe_q <= 1'b1;
        end
    end
    assign dataValidStrobe = strobe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // The synchronisers hold reset zeros for two clocks, so checks against
    // the pins wait until this count has saturated
    logic [1:0] syncAge_q;            // Clocks since reset release, stops at three

    // Saturating age counter, used only by the checks below
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncAge_q <= 2'h0;
        end else if (!(&syncAge_q)) begin
            syncAge_q <= syncAge_q + 2'h1;
        end
    end

    // Sample instant
    sequence rise_seq;
        encRise;
    endsequence

    // Neither phase edge in this clock
    sequence idle_seq;
        !encRise && !encFall;
    endsequence

    // Synchronisers filled since reset
    sequence settled_seq;
        &syncAge_q;
    endsequence

    // Falling phase edge
    sequence fall_seq;
        encFall;
    endsequence

    strobe_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        fall_seq |=> dataValidStrobe) else $error("strobe did not rise after fall");

    strobe_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        encRise |=> !dataValidStrobe) else $error("strobe did not drop on rise");

    word_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dataValidStrobe) |-> $stable(sampleWord)) else $error("word moved at strobe");

    word_fmt_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seq |=> sampleWord[TOP_BIT_POS] ==
            ($past(pipe_q[LATENCY-1].code[TOP_BIT_POS]) ^ ~$past(invSync_q[1])))
        else $error("top bit format wrong");

    flag_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seq |=> rangeOverflowFlag == $past(pipe_q[LATENCY-1].rangeOver))
        else $error("flag not from same sample");

    word_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seq |=> sampleWord[TOP_BIT_POS-1:0] == $past(pipe_q[LATENCY-1].code[TOP_BIT_POS-1:0]))
        else $error("low bits wrong");

    pipe_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        encRise |=> pipe_q[1] == $past(pipe_q[0])) else $error("pipeline did not advance");

    pipe_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !encRise |=> $stable(pipe_q[LATENCY-1])) else $error("pipeline moved without encode");

    // Gain code follows the pin two clocks late
    gain_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        settled_seq |-> gainHigh == $past(frontGainSel, 2)) else $error("gain code wrong");

    // Phase is high only for true above complement, two clocks late
    pair_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
        settled_seq |-> encHigh == ($past(encTrue, 2) & ~$past(encComp, 2))) else $error("phase decode wrong");

    word_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !encRise |=> $stable(sampleWord) && $stable(rangeOverflowFlag))
        else $error("word moved without encode rise");

    strobe_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        idle_seq |=> $stable(dataValidStrobe)) else $error("strobe moved without phase edge");

    strobe_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dataValidStrobe) |-> $past(encFall)) else $error("strobe rose without fall");

    pipe_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seq |=> pipe_q[0] == $past(coreSync_q[1])) else $error("sample not taken at rise");

    pipe_tail_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seq |=> pipe_q[LATENCY-1] == $past(pipe_q[LATENCY-2])) else $error("pipeline tail did not advance");

    core_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
        settled_seq |-> coreSync_q[1].code == $past(quantCode, 2)) else $error("core code capture wrong");

endmodule

// >>> verif/padc_capture_model.sv
// Capture-side partner model: latches word and range flag on each strobe rise
`timescale 1ns/1ns
module padc_capture_model
    import padc_pkg::*;
(
    input  wire logic              rst_n,             // Asynchronous reset, active low
    input  wire logic              dataValidStrobe,   // Strobe from the converter port
    input  wire logic [WORD_W-1:0] sampleWord,        // Parallel result word
    input  wire logic              rangeOverflowFlag, // Range flag of the same sample
    output logic [WORD_W-1:0]      capWord,           // Last captured word
    output logic                   capFlag,           // Last captured flag
    output logic [15:0]            capCount           // Captures since reset
);
    // ------------------------------------------------------------
    // Capture register
    // ------------------------------------------------------------
    // Word and flag are taken together only on the strobe rise; the count moves on the same edge
    always_ff @(posedge dataValidStrobe or negedge rst_n) begin
        if (!rst_n) begin
            capWord  <= WORD_RST;
            capFlag  <= FLAG_RST;
            capCount <= 16'h0000;
        end else begin
            capWord  <= sampleWord;
            capFlag  <= rangeOverflowFlag;
            capCount <= capCount + 16'h0001;
        end
    end
endmodule

// >>> verif/padc_output_port_tb.sv
// Self-checking bench for the converter output port
`timescale 1ns/1ns
module padc_output_port_tb
    import padc_pkg::*;
;
    localparam int NCYC = 40;                   // Encode cycles per test
    logic clk, rst_n, encTrue, encComp, quantOver, topBitInvertSel, frontGainSel;
    logic [WORD_W-1:0] quantCode, sampleWord, capWord;
    logic              rangeOverflowFlag, dataValidStrobe, gainHigh, capFlag;
    logic [15:0]       capCount;                // Strobe rises seen by the partner
    padc_sample_t      smpQ[$];                 // Samples in order of encode rise
    padc_sample_t      cur, expS;               // Sample on the pins, expected one
    int                seed = 32'h1AF85C62;     // Fixed seed keeps runs repeatable
    int                numErrors = 0;
    int                checked = 0;

    padc_output_port uut (.clk(clk), .rst_n(rst_n), .encTrue(encTrue), .encComp(encComp),
        .quantCode(quantCode), .quantOver(quantOver), .topBitInvertSel(topBitInvertSel),
        .frontGainSel(frontGainSel), .sampleWord(sampleWord), .rangeOverflowFlag(rangeOverflowFlag),
        .dataValidStrobe(dataValidStrobe), .gainHigh(gainHigh));
    padc_capture_model cap (.rst_n(rst_n), .dataValidStrobe(dataValidStrobe), .sampleWord(sampleWord),
        .rangeOverflowFlag(rangeOverflowFlag), .capWord(capWord), .capFlag(capFlag), .capCount(capCount));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Top bit flips when the format select is low
    function automatic logic [WORD_W-1:0] expWord(input logic [WORD_W-1:0] code, input logic sel);
        logic [WORD_W-1:0] r;
        r = code;
        r[TOP_BIT_POS] = code[TOP_BIT_POS] ^ ~sel;
        return r;
    endfunction
    task automatic checkWord(input string what, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
        checked++;
        if (g !== e) begin
            numErrors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic checkBit(input string what, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            numErrors++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic finishTest;
        $display("Comparisons %0d, mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // One test: reset, fixed selects, a run of encode cycles
    // ------------------------------------------------------------
    task automatic runTest(input logic sel, input logic gain);
        rst_n = 1'b0;
        topBitInvertSel = sel;
        frontGainSel = gain;
        smpQ.delete();
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        for (int i = 0; i < NCYC; i++) begin
            smpQ.push_back(cur);                 // Value standing at the rise
            encTrue = 1'b1;                      // Rising phase edge
            encComp = 1'b0;
            repeat (4) @(negedge clk);
            // Corners first: both ends and both sides of the top bit
            case (i)
                0: cur = '{rangeOver: 1'b1, code: 12'h000};
                1: cur = '{rangeOver: 1'b0, code: 12'hFFF};
                2: cur = '{rangeOver: 1'b1, code: 12'h7FF};
                3: cur = '{rangeOver: 1'b0, code: 12'h800};
                default: cur = padc_sample_t'(13'($random(seed)));
            endcase
            quantCode = cur.code;                // Changes well away from the rise
            quantOver = cur.rangeOver;
            encTrue = 1'($random(seed));         // Both high still counts as low
            encComp = 1'b1;
            repeat (4) @(negedge clk);
        end
        repeat (8) @(negedge clk);
        checkBit("gainHigh", gain, gainHigh);
        checkBit("captureCount", 1'b1, capCount == 16'(NCYC));
        $display("Test sel=%0b gain=%0b done", sel, gain);
    endtask

    // Each capture holds the sample taken five encode rises before the word moved;
    // the first five captures after reset show the cleared pipeline
    always @(capCount) begin
        #1;
        if (capCount > 16'h0005) begin
            expS = smpQ[capCount - 16'h0006];
            checkWord("sampleWord", expWord(expS.code, topBitInvertSel), capWord);
            checkBit("rangeOverflowFlag", expS.rangeOver, capFlag);
        end else if (capCount != 16'h0000) begin
            checkWord("resetWord", expWord(WORD_RST, topBitInvertSel), capWord);
            checkBit("resetFlag", FLAG_RST, capFlag);
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst_n, encTrue, topBitInvertSel, frontGainSel, quantOver} = 5'h00;
        encComp = 1'b1;
        quantCode = 12'h000;
        cur = '{rangeOver: 1'b0, code: 12'h000};
        repeat (3) @(negedge clk);
        for (int t = 0; t < 4; t++) begin
            runTest(t[0], t[1]);                 // Every format and gain pairing
        end
        finishTest;
    end
    // Watchdog: four tests take about 5.3 us
    initial begin
        #20000;
        numErrors++;
        $display("Error watchdog expected done seen timeout");
        finishTest;
    end
endmodule
